//--- bfq_top.sv
// Notes on behaviour
// - All inputs captured and all outputs launched by registers on clock edges.
// - Two separate queues, one per direction, each port on its own clock.
// - Two 18-bit bypass paths link each input register to the far output.
// - Reset pin low with select and both enables high returns all pointers.
// - Reset drives empty and almost-empty low, full and almost-full high.
// - All four threshold offsets default to 8 after reset.
// - Code 000 routes Port A to the queues, code 001 to the bypass.
// - Top select bit set picks one of four threshold registers by low bits.
// - Select deasserted disables Port A and floats its bus.
// - Port A write captures data on enable low, ignores it on enable high.
// - Port A read loads output register; output enable with select low and read direction drives bus.
// - Read with enable high holds output register and read pointer.
// - Read code 000 pops queue, 001 bypass word, 1xx threshold.
// - Bypass indicator asserts on a Port B edge after code 001 selected.
// - Indicator releases after code 000 or select high; no bypass then.
// - Bypass leaves memory alone; forward holds one word until read, any Port B write overwrites the reverse word.
// - Bypass write drops forward full and blocks writes until released.
// - Forward empty rises on Port B, falls on its read; full then rises.
// - Reverse bypass works alike using reverse empty and full.
// - Low bypass indicator means bypass; high means queue operation.
// - Port B runs on its own controls regardless of the Port A select.
`timescale 1ns/1ns
module bfq_top import bfq_pkg::*; #(
  parameter int W = DW,
  parameter int AW = QLOG
) (
  // Port A clock and core reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Port B clock
  input wire logic port_b_clk,
  // Master reset pin
  input wire logic master_reset_n,
  // Port A controls
  input wire logic port_a_select_n,
  input wire logic port_a_direction,
  input wire logic port_a_xfer_en_n,
  input wire logic port_a_drive_en_n,
  input wire logic [2:0] port_a_sel,
  // Port A bus
  input wire logic [W-1:0] port_a_bus_in,
  output logic [W-1:0] port_a_bus_out,
  output logic port_a_bus_oe,
  // Port A flags
  output logic fwd_full_n,
  output logic fwd_almost_full_n,
  output logic rev_empty_n,
  output logic rev_almost_empty_n,
  // Port B controls
  input wire logic port_b_direction,
  input wire logic port_b_xfer_en_n,
  input wire logic port_b_drive_en_n,
  // Port B bus
  input wire logic [W-1:0] port_b_bus_in,
  output logic [W-1:0] port_b_bus_out,
  output logic port_b_bus_oe,
  // Port B flags
  output logic far_side_bypass_ind_n,
  output logic fwd_empty_n,
  output logic fwd_almost_empty_n,
  output logic rev_full_n,
  output logic rev_almost_full_n
);
  typedef struct packed {
    logic rs_s1;
    logic rs_s2;
    logic enb_s1;
    logic enb_s2;
    logic rst_q;
    logic [3:0][W-1:0] thr;
    logic thr_tgl;
    logic [W-1:0] a_in;
    logic [W-1:0] a_out;
    logic bus_oe;
    logic byp_mode;
    logic ab_put;
    logic ab_ack_s1;
    logic ab_ack_s2;
    logic ba_ack;
    logic ba_put_s1;
    logic ba_put_s2;
    logic fwd_full_n;
    logic fwd_afull_n;
    logic rev_empty_n;
    logic rev_aempty_n;
  } bfq_a_t;

  typedef struct packed {
    logic rst_s1;
    logic rst_s2;
    logic mode_s1;
    logic mode_s2;
    logic byp_n;
    logic thr_s1;
    logic thr_s2;
    logic thr_seen;
    logic [W-1:0] ab_ae;
    logic [W-1:0] ba_af;
    logic [W-1:0] b_in;
    logic [W-1:0] b_out;
    logic bus_oe;
    logic ab_put_s1;
    logic ab_put_s2;
    logic ab_ack;
    logic ba_put;
    logic ba_ack_s1;
    logic ba_ack_s2;
    logic fwd_empty_n;
    logic fwd_aempty_n;
    logic rev_full_n;
    logic rev_afull_n;
  } bfq_b_t;

  bfq_a_t a, next_a;
  bfq_b_t b, next_b;

  logic a_wr, a_rd, pin_rst, rst_a, rst_b;
  logic ab_pend, ba_avail, ab_wr, ba_rd;
  logic b_wr, b_rd, b_mode, ab_avail, ba_pend, ab_rd, ba_wr;
  logic [W-1:0] thr_pick;
  logic q_ab_full, q_ab_afull, q_ab_empty, q_ab_aempty;
  logic q_ba_full, q_ba_afull, q_ba_empty, q_ba_aempty;
  logic [W-1:0] q_ab_word, q_ba_word;

  // Forward queue: Port A writes, Port B reads
  bfq_queue #(.W(W), .AW(AW)) u_fwd (
    .wclk(core_clk),
    .wrst(rst_a),
    .wr_en(ab_wr),
    .wr_data(port_a_bus_in),
    .af_ofs(a.thr[THR_AB_AF]),
    .full(q_ab_full),
    .almost_full(q_ab_afull),
    .rclk(port_b_clk),
    .rrst(rst_b),
    .rd_en(ab_rd),
    .ae_ofs(b.ab_ae),
    .rd_word(q_ab_word),
    .empty(q_ab_empty),
    .almost_empty(q_ab_aempty)
  );

  // Reverse queue: Port B writes, Port A reads
  bfq_queue #(.W(W), .AW(AW)) u_rev (
    .wclk(port_b_clk),
    .wrst(rst_b),
    .wr_en(ba_wr),
    .wr_data(port_b_bus_in),
    .af_ofs(b.ba_af),
    .full(q_ba_full),
    .almost_full(q_ba_afull),
    .rclk(core_clk),
    .rrst(rst_a),
    .rd_en(ba_rd),
    .ae_ofs(a.thr[THR_BA_AE]),
    .rd_word(q_ba_word),
    .empty(q_ba_empty),
    .almost_empty(q_ba_aempty)
  );

  // Port A domain
  always_comb begin
    next_a = a;
    a_wr = !port_a_select_n && !port_a_direction && !port_a_xfer_en_n;
    a_rd = !port_a_select_n && port_a_direction && !port_a_xfer_en_n;
    ab_pend = a.ab_put != a.ab_ack_s2;
    ba_avail = a.ba_put_s2 != a.ba_ack;
    pin_rst = !a.rs_s2 && port_a_select_n && port_a_xfer_en_n && a.enb_s2;
    rst_a = sys_rst || pin_rst;
    ab_wr = a_wr && port_a_sel == SEL_QUEUE;
    ba_rd = a_rd && port_a_sel == SEL_QUEUE && !q_ba_empty;
    thr_pick = a.thr[port_a_sel[1:0]];
    next_a.rs_s1 = master_reset_n;
    next_a.rs_s2 = a.rs_s1;
    next_a.enb_s1 = port_b_xfer_en_n;
    next_a.enb_s2 = a.enb_s1;
    next_a.ab_ack_s1 = b.ab_ack;
    next_a.ab_ack_s2 = a.ab_ack_s1;
    next_a.ba_put_s1 = b.ba_put;
    next_a.ba_put_s2 = a.ba_put_s1;
    if (a_wr) begin
      if (port_a_sel == SEL_QUEUE) begin
        next_a.a_in = port_a_bus_in;
      end else if (port_a_sel == SEL_BYPASS && !ab_pend) begin
        next_a.a_in = port_a_bus_in;
        next_a.ab_put = !a.ab_put;
      end else if (port_a_sel[SEL_THR_BIT]) begin
        next_a.thr[port_a_sel[1:0]] = port_a_bus_in;
        next_a.thr_tgl = !a.thr_tgl;
      end
    end
    if (ba_rd) begin
      next_a.a_out = q_ba_word;
    end else if (a_rd && port_a_sel == SEL_BYPASS && ba_avail) begin
      next_a.a_out = b.b_in;
      next_a.ba_ack = !a.ba_ack;
    end else if (a_rd && port_a_sel[SEL_THR_BIT]) begin
      next_a.a_out = thr_pick;
    end
    next_a.bus_oe = !port_a_select_n && port_a_direction && !port_a_drive_en_n;
    next_a.byp_mode = !port_a_select_n && port_a_sel == SEL_BYPASS;
    // Unread reverse bypass word is dropped on leaving bypass
    if (a.byp_mode && !next_a.byp_mode) begin
      next_a.ba_ack = next_a.ba_put_s2;
    end
    if (next_a.byp_mode) begin
      next_a.fwd_full_n = next_a.ab_put == next_a.ab_ack_s2;
      next_a.rev_empty_n = next_a.ba_put_s2 != next_a.ba_ack;
    end else begin
      next_a.fwd_full_n = !q_ab_full;
      next_a.rev_empty_n = !q_ba_empty;
    end
    next_a.fwd_afull_n = !q_ab_afull;
    next_a.rev_aempty_n = !q_ba_aempty;
    if (rst_a) begin
      next_a.thr = {4{W'(OFS_RESET)}};
      next_a.thr_tgl = 1'b0;
      next_a.a_in = '0;
      next_a.a_out = '0;
      next_a.bus_oe = 1'b0;
      next_a.byp_mode = 1'b0;
      next_a.ab_put = 1'b0;
      next_a.ba_ack = 1'b0;
      next_a.fwd_full_n = 1'b1;
      next_a.fwd_afull_n = 1'b1;
      next_a.rev_empty_n = 1'b0;
      next_a.rev_aempty_n = 1'b0;
    end
    next_a.rst_q = rst_a;
  end

  always_ff @(posedge core_clk) begin
    a <= next_a;
  end

  // Port B domain
  always_comb begin
    next_b = b;
    rst_b = b.rst_s2;
    b_wr = !port_b_direction && !port_b_xfer_en_n;
    b_rd = port_b_direction && !port_b_xfer_en_n;
    b_mode = !b.byp_n;
    ab_avail = b.ab_put_s2 != b.ab_ack;
    ba_pend = b.ba_put != b.ba_ack_s2;
    ab_rd = b_rd && !b_mode && !q_ab_empty;
    ba_wr = b_wr && !b_mode;
    next_b.rst_s1 = a.rst_q;
    next_b.rst_s2 = b.rst_s1;
    next_b.mode_s1 = a.byp_mode;
    next_b.mode_s2 = b.mode_s1;
    next_b.thr_s1 = a.thr_tgl;
    next_b.thr_s2 = b.thr_s1;
    next_b.ab_put_s1 = a.ab_put;
    next_b.ab_put_s2 = b.ab_put_s1;
    next_b.ba_ack_s1 = a.ba_ack;
    next_b.ba_ack_s2 = b.ba_ack_s1;
    // Thresholds copied after a toggle; values are stable by then
    if (b.thr_s2 != b.thr_seen) begin
      next_b.thr_seen = b.thr_s2;
      next_b.ab_ae = a.thr[THR_AB_AE];
      next_b.ba_af = a.thr[THR_BA_AF];
    end
    if (b_wr) begin
      next_b.b_in = port_b_bus_in;
      if (b_mode && !ba_pend) begin
        next_b.ba_put = !b.ba_put;
      end
    end
    if (b_rd && b_mode && ab_avail) begin
      next_b.b_out = a.a_in;
      next_b.ab_ack = !b.ab_ack;
    end else if (ab_rd) begin
      next_b.b_out = q_ab_word;
    end
    next_b.bus_oe = port_b_direction && !port_b_drive_en_n;
    next_b.byp_n = !b.mode_s2;
    // Last edge in bypass still serves a read, then the word is dropped
    if (b_mode && next_b.byp_n) begin
      next_b.ab_ack = next_b.ab_put_s2;
    end
    if (!next_b.byp_n) begin
      next_b.fwd_empty_n = next_b.ab_put_s2 != next_b.ab_ack;
      next_b.rev_full_n = next_b.ba_put == next_b.ba_ack_s2;
    end else begin
      next_b.fwd_empty_n = !q_ab_empty;
      next_b.rev_full_n = !q_ba_full;
    end
    next_b.fwd_aempty_n = !q_ab_aempty;
    next_b.rev_afull_n = !q_ba_afull;
    if (rst_b) begin
      next_b.byp_n = 1'b1;
      next_b.thr_seen = b.thr_s2;
      next_b.ab_ae = W'(OFS_RESET);
      next_b.ba_af = W'(OFS_RESET);
      next_b.b_in = '0;
      next_b.b_out = '0;
      next_b.bus_oe = 1'b0;
      next_b.ab_ack = 1'b0;
      next_b.ba_put = 1'b0;
      next_b.fwd_empty_n = 1'b0;
      next_b.fwd_aempty_n = 1'b0;
      next_b.rev_full_n = 1'b1;
      next_b.rev_afull_n = 1'b1;
    end
  end

  always_ff @(posedge port_b_clk) begin
    b <= next_b;
  end

  assign port_a_bus_out = a.a_out;
  assign port_a_bus_oe = a.bus_oe;
  assign fwd_full_n = a.fwd_full_n;
  assign fwd_almost_full_n = a.fwd_afull_n;
  assign rev_empty_n = a.rev_empty_n;
  assign rev_almost_empty_n = a.rev_aempty_n;
  assign port_b_bus_out = b.b_out;
  assign port_b_bus_oe = b.bus_oe;
  assign far_side_bypass_ind_n = b.byp_n;
  assign fwd_empty_n = b.fwd_empty_n;
  assign fwd_almost_empty_n = b.fwd_aempty_n;
  assign rev_full_n = b.rev_full_n;
  assign rev_almost_full_n = b.rev_afull_n;

  chk_bus_float: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    port_a_select_n |=> !port_a_bus_oe
  ) else $error("Port A bus driven while deselected");

  chk_reset_flags: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    pin_rst |=> !rev_empty_n && !rev_almost_empty_n && fwd_full_n && fwd_almost_full_n
  ) else $error("Port A flags wrong after reset");

  chk_thr_default: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    pin_rst ##1 !rst_a && port_a_select_n |=> a.thr[THR_BA_AE] == W'(OFS_RESET)
  ) else $error("Threshold not at default after reset");

  chk_byp_full: assert property (
    @(posedge core_clk) disable iff (rst_a)
    a_wr && port_a_sel == SEL_BYPASS && !ab_pend |=> !fwd_full_n ##1 ab_pend
  ) else $error("Forward full not low after bypass write");

  chk_hold_out: assert property (
    @(posedge core_clk) disable iff (rst_a)
    !port_a_select_n && port_a_direction && port_a_xfer_en_n |=> $stable(port_a_bus_out)
  ) else $error("Output register changed with enable high");

  chk_thr_read: assert property (
    @(posedge core_clk) disable iff (rst_a)
    a_rd && port_a_sel[SEL_THR_BIT] |=> port_a_bus_out == $past(thr_pick)
  ) else $error("Threshold read returned wrong value");

  chk_queue_pop: assert property (
    @(posedge core_clk) disable iff (rst_a)
    ba_rd |=> port_a_bus_out == $past(q_ba_word)
  ) else $error("Queue read did not load the head word");

  chk_byp_ind: assert property (
    @(posedge port_b_clk) disable iff (rst_b)
    $rose(b.mode_s2) |=> !far_side_bypass_ind_n [*1] ##0 $fell(far_side_bypass_ind_n)
  ) else $error("Bypass indicator late");
endmodule // bfq_top

//--- bfq_pkg.sv
package bfq_pkg;
  // Data width and queue depth (log2)
  localparam int DW = 18;
  localparam int QLOG = 9;
  // Threshold value after reset
  localparam logic [17:0] OFS_RESET = 18'h0_0008;
  // Port A select codes
  localparam logic [2:0] SEL_QUEUE = 3'h0;
  localparam logic [2:0] SEL_BYPASS = 3'h1;
  localparam int SEL_THR_BIT = 2;
  // Threshold register index under the low two select bits
  localparam logic [1:0] THR_AB_AE = 2'h0;
  localparam logic [1:0] THR_AB_AF = 2'h1;
  localparam logic [1:0] THR_BA_AE = 2'h2;
  localparam logic [1:0] THR_BA_AF = 2'h3;
endpackage

//--- bfq_queue.sv
`timescale 1ns/1ns
module bfq_queue import bfq_pkg::*; #(
  parameter int W = DW,
  parameter int AW = QLOG
) (
  // Write side
  input wire logic wclk,
  input wire logic wrst,
  input wire logic wr_en,
  input wire logic [W-1:0] wr_data,
  input wire logic [W-1:0] af_ofs,
  output logic full,
  output logic almost_full,
  // Read side
  input wire logic rclk,
  input wire logic rrst,
  input wire logic rd_en,
  input wire logic [W-1:0] ae_ofs,
  output logic [W-1:0] rd_word,
  output logic empty,
  output logic almost_empty
);
  localparam int PW = AW + 1;
  localparam logic [PW-1:0] DEPTH = PW'(1 << AW);

  function automatic logic [PW-1:0] to_gray(input logic [PW-1:0] b);
    return b ^ (b >> 1);
  endfunction

  function automatic logic [PW-1:0] to_bin(input logic [PW-1:0] g);
    logic [PW-1:0] b;
    b[PW-1] = g[PW-1];
    for (int i = PW - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

  typedef struct packed {
    logic [(1<<AW)-1:0][W-1:0] mem;
    logic [PW-1:0] wptr;
    logic [PW-1:0] wgray;
    logic [PW-1:0] rg_s1;
    logic [PW-1:0] rg_s2;
  } bfq_wst_t;

  typedef struct packed {
    logic [PW-1:0] rptr;
    logic [PW-1:0] rgray;
    logic [PW-1:0] wg_s1;
    logic [PW-1:0] wg_s2;
  } bfq_rst_t;

  bfq_wst_t ws, next_ws;
  bfq_rst_t rs, next_rs;
  logic [PW-1:0] wcount;
  logic [PW-1:0] rcount;

  // Full flags in the writer's domain against a synced gray read pointer
  always_comb begin
    next_ws = ws;
    wcount = ws.wptr - to_bin(ws.rg_s2);
    full = wcount == DEPTH;
    almost_full = wcount >= DEPTH - af_ofs[PW-1:0];
    if (wr_en && !full) begin
      next_ws.mem[ws.wptr[AW-1:0]] = wr_data;
      next_ws.wptr = ws.wptr + 1'b1;
    end
    next_ws.wgray = to_gray(next_ws.wptr);
    next_ws.rg_s1 = rs.rgray;
    next_ws.rg_s2 = ws.rg_s1;
  end

  always_ff @(posedge wclk) begin
    if (wrst) begin
      ws <= '0;
    end else begin
      ws <= next_ws;
    end
  end

  // Empty flags in the reader's domain; the addressed word is stable
  always_comb begin
    next_rs = rs;
    rcount = to_bin(rs.wg_s2) - rs.rptr;
    empty = rcount == '0;
    almost_empty = rcount <= ae_ofs[PW-1:0];
    rd_word = ws.mem[rs.rptr[AW-1:0]];
    if (rd_en && !empty) begin
      next_rs.rptr = rs.rptr + 1'b1;
    end
    next_rs.rgray = to_gray(next_rs.rptr);
    next_rs.wg_s1 = ws.wgray;
    next_rs.wg_s2 = rs.wg_s1;
  end

  always_ff @(posedge rclk) begin
    if (rrst) begin
      rs <= '0;
    end else begin
      rs <= next_rs;
    end
  end
endmodule // bfq_queue

//--- bfq_pb_model.sv
`timescale 1ns/1ns
module bfq_pb_model (
  // Port B clock
  input wire logic port_b_clk,
  // Controls and data toward the device
  output logic port_b_direction,
  output logic port_b_xfer_en_n,
  output logic port_b_drive_en_n,
  output logic [17:0] port_b_bus_in,
  // Output register of the device
  input wire logic [17:0] port_b_bus_out
);
  // Idle with enable high so a pin reset can take effect
  initial begin
    port_b_direction = 1'b0;
    port_b_xfer_en_n = 1'b1;
    port_b_drive_en_n = 1'b1;
    port_b_bus_in = 18'h0_0000;
  end

  // One word written on the next rising edge
  task automatic write_word(input logic [17:0] d);
    @(negedge port_b_clk);
    port_b_direction = 1'b0;
    port_b_bus_in = d;
    port_b_xfer_en_n = 1'b0;
    @(negedge port_b_clk);
    port_b_xfer_en_n = 1'b1;
    port_b_bus_in = ~d;
  endtask

  // Output buffer switched on or off at the next edge; the caller checks the enable right after
  task automatic set_drive(input logic on);
    @(negedge port_b_clk);
    port_b_direction = 1'b1;
    port_b_drive_en_n = ~on;
    @(negedge port_b_clk);
  endtask

  // One word read into the output register, then sampled
  task automatic read_word(output logic [17:0] q);
    @(negedge port_b_clk);
    port_b_direction = 1'b1;
    port_b_xfer_en_n = 1'b0;
    @(negedge port_b_clk);
    port_b_xfer_en_n = 1'b1;
    @(negedge port_b_clk);
    q = port_b_bus_out;
  endtask
endmodule // bfq_pb_model

//--- tb.sv
`timescale 1ns/1ns
module tb import bfq_pkg::*; ();
  logic core_clk = 1'b0;
  logic port_b_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic master_reset_n = 1'b1;
  logic port_a_select_n = 1'b1;
  logic port_a_direction = 1'b0;
  logic port_a_xfer_en_n = 1'b1;
  logic port_a_drive_en_n = 1'b1;
  logic [2:0] port_a_sel = 3'h0;
  logic [17:0] port_a_bus_in = 18'h0_0000;
  logic [17:0] port_a_bus_out, port_b_bus_out, port_b_bus_in;
  logic port_a_bus_oe, port_b_bus_oe, port_b_direction, port_b_xfer_en_n, port_b_drive_en_n;
  logic fwd_full_n, fwd_almost_full_n, rev_empty_n, rev_almost_empty_n;
  logic far_side_bypass_ind_n, fwd_empty_n, fwd_almost_empty_n, rev_full_n, rev_almost_full_n;
  int n_mismatch = 0;
  int checks = 0;
  int cyc = 0;
  int seed = 32'h3609523e;
  logic [17:0] fq[$];
  logic [17:0] rq[$];
  logic [17:0] thr[4];
  logic [17:0] w, q;

  always #2 core_clk = ~core_clk;
  always begin
    #62 port_b_clk = ~port_b_clk;
    #63 port_b_clk = ~port_b_clk;
  end

  bfq_top i_dut (.core_clk(core_clk), .sys_rst(sys_rst), .port_b_clk(port_b_clk),
    .master_reset_n(master_reset_n), .port_a_select_n(port_a_select_n),
    .port_a_direction(port_a_direction), .port_a_xfer_en_n(port_a_xfer_en_n),
    .port_a_drive_en_n(port_a_drive_en_n), .port_a_sel(port_a_sel),
    .port_a_bus_in(port_a_bus_in), .port_a_bus_out(port_a_bus_out),
    .port_a_bus_oe(port_a_bus_oe), .fwd_full_n(fwd_full_n),
    .fwd_almost_full_n(fwd_almost_full_n), .rev_empty_n(rev_empty_n),
    .rev_almost_empty_n(rev_almost_empty_n), .port_b_direction(port_b_direction),
    .port_b_xfer_en_n(port_b_xfer_en_n), .port_b_drive_en_n(port_b_drive_en_n),
    .port_b_bus_in(port_b_bus_in), .port_b_bus_out(port_b_bus_out),
    .port_b_bus_oe(port_b_bus_oe), .far_side_bypass_ind_n(far_side_bypass_ind_n),
    .fwd_empty_n(fwd_empty_n), .fwd_almost_empty_n(fwd_almost_empty_n),
    .rev_full_n(rev_full_n), .rev_almost_full_n(rev_almost_full_n));

  bfq_pb_model i_pb (.port_b_clk(port_b_clk), .port_b_direction(port_b_direction),
    .port_b_xfer_en_n(port_b_xfer_en_n), .port_b_drive_en_n(port_b_drive_en_n),
    .port_b_bus_in(port_b_bus_in), .port_b_bus_out(port_b_bus_out));

  task automatic cmp_word(input logic [17:0] got, input logic [17:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: word %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_flag(input logic [8:0] got, input logic [8:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: flags %b, expected %b", $time, got, exp);
    end
  endtask

  // Flag picked by index: empties, fulls, bypass indicator
  function automatic logic flag(input int k);
    case (k)
      0: return fwd_empty_n;
      1: return rev_empty_n;
      2: return fwd_full_n;
      3: return rev_full_n;
      default: return far_side_bypass_ind_n;
    endcase
  endfunction

  // Bounded wait across the clock crossing, then compare
  task automatic wait_flag(input int k, input logic v);
    int i;
    i = 0;
    while (flag(k) !== v && i < 400) begin
      @(negedge core_clk);
      i++;
    end
    cmp_flag({8'h00, flag(k)}, {8'h00, v});
  endtask

  // Port A transfer: select, one enabled or idle edge, sample later
  task automatic a_op(input logic rd, input logic [2:0] sel, input logic en,
      input logic [17:0] d);
    @(negedge core_clk);
    port_a_select_n = 1'b0;
    port_a_sel = sel;
    @(negedge core_clk);
    port_a_direction = rd;
    port_a_bus_in = d;
    port_a_xfer_en_n = ~en;
    @(negedge core_clk);
    port_a_xfer_en_n = 1'b1;
    port_a_bus_in = ~d;
    repeat (2) @(negedge core_clk);
    q = port_a_bus_out;
  endtask

  task automatic results;
    $display("Comparisons %0d, mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      $display("Error at %0t: run did not finish in time", $time);
      results();
    end
  end

  initial begin
    repeat (2) @(negedge core_clk);
    sys_rst = 1'b0;
    master_reset_n = 1'b0;
    repeat (6) @(negedge port_b_clk);
    master_reset_n = 1'b1;
    repeat (5) @(negedge port_b_clk);
    cmp_flag({fwd_empty_n, rev_empty_n, fwd_almost_empty_n, rev_almost_empty_n, fwd_full_n,
      rev_full_n, fwd_almost_full_n, rev_almost_full_n, far_side_bypass_ind_n}, 9'h01f);
    for (int k = 0; k < 4; k++) begin
      a_op(1'b1, {1'b1, 2'(k)}, 1'b1, 18'h0_0000);
      cmp_word(q, OFS_RESET);
      thr[k] = 18'($random(seed));
      a_op(1'b0, {1'b1, 2'(k)}, 1'b1, thr[k]);
    end
    for (int k = 0; k < 4; k++) begin
      a_op(1'b1, {1'b1, 2'(k)}, 1'b1, 18'h0_0000);
      cmp_word(q, thr[k]);
    end
    for (int i = 0; i < 6; i++) begin
      w = 18'($random(seed));
      a_op(1'b0, SEL_QUEUE, i != 2, w);
      if (i != 2) fq.push_back(w);
    end
    wait_flag(0, 1'b1);
    while (fq.size() > 0) begin
      i_pb.read_word(w);
      cmp_word(w, fq.pop_front());
    end
    wait_flag(0, 1'b0);
    i_pb.set_drive(1'b1);
    cmp_flag({8'h00, port_b_bus_oe}, 9'h001);
    i_pb.set_drive(1'b0);
    cmp_flag({8'h00, port_b_bus_oe}, 9'h000);
    for (int i = 0; i < 4; i++) begin
      w = 18'($random(seed));
      i_pb.write_word(w);
      rq.push_back(w);
    end
    wait_flag(1, 1'b1);
    while (rq.size() > 0) begin
      w = rq.pop_front();
      a_op(1'b1, SEL_QUEUE, 1'b1, 18'h0_0000);
      cmp_word(q, w);
      a_op(1'b1, SEL_QUEUE, 1'b0, 18'h0_0000);
      cmp_word(q, w);
    end
    wait_flag(1, 1'b0);
    port_a_direction = 1'b1;
    port_a_drive_en_n = 1'b0;
    repeat (3) @(negedge core_clk);
    cmp_flag({8'h00, port_a_bus_oe}, 9'h001);
    port_a_select_n = 1'b1;
    repeat (3) @(negedge core_clk);
    cmp_flag({8'h00, port_a_bus_oe}, 9'h000);
    port_a_drive_en_n = 1'b1;
    repeat (2) @(negedge core_clk);
    port_a_direction = 1'b0;
    port_a_bus_in = 18'h2_a5a5;
    port_a_xfer_en_n = 1'b0;
    @(negedge core_clk);
    port_a_xfer_en_n = 1'b1;
    repeat (150) @(negedge core_clk);
    cmp_flag({8'h00, fwd_empty_n}, 9'h000);
    a_op(1'b0, SEL_BYPASS, 1'b0, 18'h0_0000);
    wait_flag(4, 1'b0);
    w = 18'($random(seed));
    a_op(1'b0, SEL_BYPASS, 1'b1, w);
    cmp_flag({8'h00, fwd_full_n}, 9'h000);
    a_op(1'b0, SEL_BYPASS, 1'b1, ~w);
    wait_flag(0, 1'b1);
    i_pb.read_word(q);
    cmp_word(q, w);
    wait_flag(0, 1'b0);
    wait_flag(2, 1'b1);
    w = 18'($random(seed));
    i_pb.write_word(w);
    wait_flag(1, 1'b1);
    a_op(1'b1, SEL_BYPASS, 1'b1, 18'h0_0000);
    cmp_word(q, w);
    wait_flag(1, 1'b0);
    a_op(1'b0, SEL_QUEUE, 1'b0, 18'h0_0000);
    wait_flag(4, 1'b1);
    cmp_flag({7'h00, fwd_empty_n, rev_empty_n}, 9'h000);
    results();
  end
endmodule // tb
